// ### rtl/cprf_pkg.sv
package cprf_pkg;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [7:0] H_RST = 8'h00;
  localparam logic [15:0] VEC_HI = 16'hFFFE;
  localparam logic [15:0] VEC_LO = 16'hFFFF;
  localparam logic [7:0] DIR_PAGE = 8'h00;
  localparam logic [7:0] CCR_ONES = 8'h60;
  localparam logic [7:0] CCR_RST = 8'h68;
  localparam logic [7:0] SP_LOW_RELOAD = 8'hFF;
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam logic [15:0] RET_BYTES = 16'h0002;
  localparam logic [15:0] INT_BYTES = 16'h0005;

  typedef enum logic [5:0] {
    OP_NOP, OP_LDA, OP_LDX, OP_LDHX, OP_TAX, OP_TXA,
    OP_ADD, OP_ADC, OP_SUB,
    OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX,
    OP_LSLX, OP_LSRX, OP_ASRX, OP_ROLX, OP_RORX,
    OP_MUL, OP_DIV, OP_AIS, OP_RSP, OP_TXS, OP_TSX,
    OP_CALL, OP_RTS, OP_INT, OP_RTI, OP_MOV,
    OP_BRA, OP_BEQ, OP_BCS, OP_BLT
  } cprf_op_t;

  typedef enum logic [3:0] {
    AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX, AM_IX1, AM_IX2,
    AM_IXP, AM_IX1P, AM_SP1, AM_REL
  } cprf_mode_t;

  typedef enum logic [1:0] {MV_DD, MV_DIXP, MV_IMMD, MV_IXPD} cprf_mov_t;

  typedef struct packed {
    cprf_op_t op;
    cprf_mode_t mode;
    cprf_mov_t mov;
    logic [1:0] len;
    logic [15:0] opr;
    logic [7:0] aux;
  } cprf_cmd_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] ccr;
  } cprf_regs_t;
endpackage

// ### rtl/cprf_core.sv
`timescale 1ns/1ps
module cprf_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input cprf_pkg::cprf_cmd_t cmd,
  input wire logic [7:0] vec_data,
  output logic ready,
  output logic [15:0] vec_addr,
  output cprf_pkg::cprf_regs_t regs,
  output logic [15:0] ea,
  output logic [15:0] ea2
);
  import cprf_pkg::*;

  typedef enum logic [1:0] {ST_VEC_HI, ST_VEC_LO, ST_RUN} cprf_st_t;

  cprf_st_t st_q, st_d;
  logic [7:0] a_q, a_d, x_q, x_d, h_q, h_d, ccr_q, ccr_d;
  logic [15:0] sp_q, sp_d, pc_q, pc_d, ea_q, ea_d, ea2_q, ea2_d;
  logic [15:0] vaddr_q, vaddr_d, hx, npc, prod;
  logic [10:0] sum;
  logic [8:0] sh;
  logic [15:0] quo;
  logic [7:0] rem;

  function automatic logic [15:0] sext8(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  function automatic logic [15:0] zext8(input logic [7:0] v);
    return {DIR_PAGE, v};
  endfunction

  // Result packs {v, h, c, r[7:0]}
  function automatic logic [10:0] add8(input logic [7:0] p, input logic [7:0] q,
                                       input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, p} + {1'b0, q} + {8'h00, ci};
    n = {1'b0, p[3:0]} + {1'b0, q[3:0]} + {4'h0, ci};
    return {(p[7] == q[7]) && (s[7] != p[7]), n[4], s[8], s[7:0]};
  endfunction

  function automatic logic [7:0] nz(input logic [7:0] c, input logic [7:0] r);
    logic [7:0] o;
    o = c;
    o[CCR_N] = r[7];
    o[CCR_Z] = (r == 8'h00);
    return o;
  endfunction

  function automatic logic [15:0] ea_calc(input cprf_mode_t m, input logic [15:0] o,
                                          input logic [15:0] p, input logic [15:0] s);
    case (m)
      AM_DIR: return zext8(o[7:0]);
      AM_EXT: return o;
      AM_IX, AM_IXP: return p;
      AM_IX1, AM_IX1P: return p + zext8(o[7:0]);
      AM_IX2: return p + o;
      AM_SP1: return s + zext8(o[7:0]);
      default: return o;
    endcase
  endfunction

  assign hx = {h_q, x_q};
  assign npc = pc_q + {14'h0000, cmd.len};

  always_comb begin
    st_d = st_q;
    vaddr_d = vaddr_q;
    a_d = a_q;
    x_d = x_q;
    h_d = h_q;
    sp_d = sp_q;
    pc_d = pc_q;
    ccr_d = ccr_q;
    ea_d = ea_q;
    ea2_d = ea2_q;
    sum = 11'h000;
    sh = 9'h000;
    prod = {8'h00, x_q} * {8'h00, a_q};
    quo = 16'h0000;
    rem = 8'h00;
    case (st_q)
      ST_VEC_HI: begin
        pc_d[15:8] = vec_data;
        vaddr_d = VEC_LO;
        st_d = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        pc_d[7:0] = vec_data;
        st_d = ST_RUN;
      end
      default: begin
        if (cmd_valid) begin
          pc_d = npc;
          ea_d = ea_calc(cmd.mode, cmd.opr, hx, sp_q);
          if (cmd.mode == AM_IXP || cmd.mode == AM_IX1P) begin
            {h_d, x_d} = hx + 16'h0001;
          end
          case (cmd.op)
            OP_LDA: begin
              // Immediate takes the first trailing byte
              a_d = cmd.opr[7:0];
              ccr_d = nz(ccr_q, a_d);
              ccr_d[CCR_V] = 1'b0;
            end
            OP_LDX: begin
              x_d = cmd.opr[7:0];
              ccr_d = nz(ccr_q, x_d);
              ccr_d[CCR_V] = 1'b0;
            end
            OP_LDHX: begin
              {h_d, x_d} = cmd.opr;
              ccr_d[CCR_N] = cmd.opr[15];
              ccr_d[CCR_Z] = (cmd.opr == 16'h0000);
              ccr_d[CCR_V] = 1'b0;
            end
            OP_TAX: x_d = a_q;
            OP_TXA: a_d = x_q;
            OP_ADD, OP_ADC, OP_SUB: begin
              if (cmd.op == OP_SUB) begin
                sum = add8(a_q, ~cmd.opr[7:0], 1'b1);
                sum[8] = ~sum[8];
              end else begin
                sum = add8(a_q, cmd.opr[7:0], (cmd.op == OP_ADC) & ccr_q[CCR_C]);
              end
              a_d = sum[7:0];
              ccr_d = nz(ccr_q, a_d);
              ccr_d[CCR_V] = sum[10];
              ccr_d[CCR_C] = sum[8];
              if (cmd.op != OP_SUB) begin
                ccr_d[CCR_H] = sum[9];
              end
            end
            OP_CLRX, OP_INCX, OP_DECX, OP_COMX, OP_NEGX: begin
              case (cmd.op)
                OP_CLRX: x_d = 8'h00;
                OP_INCX: x_d = x_q + 8'h01;
                OP_DECX: x_d = x_q - 8'h01;
                OP_COMX: x_d = ~x_q;
                default: x_d = 8'h00 - x_q;
              endcase
              ccr_d = nz(ccr_q, x_d);
              case (cmd.op)
                OP_CLRX: ccr_d[CCR_V] = 1'b0;
                OP_INCX: ccr_d[CCR_V] = (x_d == 8'h80);
                OP_DECX: ccr_d[CCR_V] = (x_d == 8'h7F);
                OP_COMX: begin
                  ccr_d[CCR_V] = 1'b0;
                  ccr_d[CCR_C] = 1'b1;
                end
                default: begin
                  ccr_d[CCR_V] = (x_d == 8'h80);
                  ccr_d[CCR_C] = (x_d != 8'h00);
                end
              endcase
            end
            OP_LSLX, OP_LSRX, OP_ASRX, OP_ROLX, OP_RORX: begin
              case (cmd.op)
                OP_LSLX: sh = {x_q, 1'b0};
                OP_ROLX: sh = {x_q, ccr_q[CCR_C]};
                OP_LSRX: sh = {x_q[0], 1'b0, x_q[7:1]};
                OP_ASRX: sh = {x_q[0], x_q[7], x_q[7:1]};
                default: sh = {x_q[0], ccr_q[CCR_C], x_q[7:1]};
              endcase
              x_d = sh[7:0];
              ccr_d = nz(ccr_q, x_d);
              ccr_d[CCR_C] = sh[8];
              ccr_d[CCR_V] = sh[8] ^ x_d[7];
            end
            OP_MUL: begin
              {x_d, a_d} = prod;
              ccr_d[CCR_H] = 1'b0;
              ccr_d[CCR_C] = 1'b0;
            end
            OP_DIV: begin
              // Divide by zero or a quotient over 8 bits sets carry, A and H hold
              if (x_q == 8'h00) begin
                ccr_d[CCR_C] = 1'b1;
              end else begin
                quo = {h_q, a_q} / zext8(x_q);
                rem = 8'(({h_q, a_q} % zext8(x_q)));
                ccr_d[CCR_C] = (quo[15:8] != 8'h00);
                if (quo[15:8] == 8'h00) begin
                  a_d = quo[7:0];
                  h_d = rem;
                  ccr_d[CCR_Z] = (quo[7:0] == 8'h00);
                end
              end
            end
            OP_AIS: sp_d = sp_q + sext8(cmd.opr[7:0]);
            OP_RSP: sp_d[7:0] = SP_LOW_RELOAD;
            OP_TXS: sp_d = hx - 16'h0001;
            OP_TSX: {h_d, x_d} = sp_q + 16'h0001;
            OP_CALL: begin
              // Return address goes to sp and sp-1
              ea_d = sp_q;
              sp_d = sp_q - RET_BYTES;
              pc_d = ea_calc(cmd.mode, cmd.opr, hx, sp_q);
            end
            OP_RTS: begin
              sp_d = sp_q + RET_BYTES;
              pc_d = cmd.opr;
            end
            OP_INT: begin
              // Frame: pc, x, a, ccr; h stays for compatibility
              ea_d = sp_q;
              sp_d = sp_q - INT_BYTES;
              ccr_d[CCR_I] = 1'b1;
              pc_d = cmd.opr;
            end
            OP_RTI: begin
              sp_d = sp_q + INT_BYTES;
              ccr_d = cmd.aux;
              pc_d = cmd.opr;
            end
            OP_MOV: begin
              // ea is the source, ea2 the destination
              case (cmd.mov)
                MV_DD: begin
                  ea_d = zext8(cmd.opr[15:8]);
                  ea2_d = zext8(cmd.opr[7:0]);
                end
                MV_DIXP: begin
                  ea_d = zext8(cmd.opr[7:0]);
                  ea2_d = hx;
                  {h_d, x_d} = hx + 16'h0001;
                end
                MV_IMMD: begin
                  ea_d = pc_q + 16'h0001;
                  ea2_d = zext8(cmd.opr[7:0]);
                end
                default: begin
                  ea_d = hx;
                  ea2_d = zext8(cmd.opr[7:0]);
                  {h_d, x_d} = hx + 16'h0001;
                end
              endcase
            end
            OP_BRA, OP_BEQ, OP_BCS, OP_BLT: begin
              if (cmd.op == OP_BRA || (cmd.op == OP_BEQ && ccr_q[CCR_Z]) ||
                  (cmd.op == OP_BCS && ccr_q[CCR_C]) ||
                  (cmd.op == OP_BLT && (ccr_q[CCR_N] ^ ccr_q[CCR_V]))) begin
                pc_d = npc + sext8(cmd.opr[7:0]);
              end
            end
            default: ;
          endcase
        end
      end
    endcase
    ccr_d = ccr_d | CCR_ONES;
  end

  // Data registers keep their contents across reset, even if a command is offered then
  always_ff @(posedge clk) begin
    if (rst_n) begin
      a_q <= a_d;
      x_q <= x_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_VEC_HI;
      vaddr_q <= VEC_HI;
      h_q <= H_RST;
      sp_q <= SP_RST;
      pc_q <= 16'h0000;
      ccr_q <= CCR_RST;
      ea_q <= 16'h0000;
      ea2_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      vaddr_q <= vaddr_d;
      h_q <= h_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      ccr_q <= ccr_d;
      ea_q <= ea_d;
      ea2_q <= ea2_d;
    end
  end

  // Registers are seen only on these ports, never through a bus decode
  assign ready = (st_q == ST_RUN);
  assign vec_addr = vaddr_q;
  assign regs = '{acc: a_q, hx: hx, sp: sp_q, pc: pc_q, ccr: ccr_q};
  assign ea = ea_q;
  assign ea2 = ea2_q;
endmodule // cprf_core

// ### test/cprf_core_asserts.sv
`timescale 1ns/1ps
module cprf_core_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input cprf_pkg::cprf_cmd_t cmd,
  input wire logic [7:0] vec_data,
  input wire logic ready,
  input wire logic [15:0] vec_addr,
  input cprf_pkg::cprf_regs_t regs,
  input wire logic [15:0] ea,
  input wire logic [15:0] ea2
);
  import cprf_pkg::*;
  logic tk;
  logic run_d;
  logic run_q;
  logic [15:0] rel;
  assign tk = cmd_valid && ready && rst_n;
  assign rel = {{8{cmd.opr[7]}}, cmd.opr[7:0]};
  // Acc and x are unknown until loaded, so the keep check waits for an LDX
  always_comb begin
    run_d = run_q | (tk && cmd.op == OP_LDX);
  end
  always_ff @(posedge clk) begin
    run_q <= run_d;
  end
  default clocking cb @(posedge clk); endclocking
  reset_vals_a: assert property (!rst_n |=> regs.sp == SP_RST && regs.hx[15:8] == H_RST)
    else $error("reset values wrong");
  keep_reset_a: assert property (run_q && !rst_n |=> regs.acc == $past(regs.acc)
    && regs.hx[7:0] == $past(regs.hx[7:0])) else $error("acc or x lost in reset");
  ccr_ones_a: assert property (disable iff (!rst_n) regs.ccr[6:5] == 2'b11)
    else $error("ccr fixed bits wrong");
  vec_load_a: assert property ($rose(rst_n) |-> vec_addr == VEC_HI && !ready
    ##1 vec_addr == VEC_LO && !ready
    ##1 ready && regs.pc == {$past(vec_data, 2), $past(vec_data)}) else $error("vector bad");
  ais_add_a: assert property (disable iff (!rst_n) tk && cmd.op == OP_AIS
    |=> regs.sp == $past(regs.sp) + $past(rel)) else $error("stack adjust wrong");
  rsp_low_a: assert property (disable iff (!rst_n) tk && cmd.op == OP_RSP
    |=> regs.sp == {$past(regs.sp[15:8]), SP_LOW_RELOAD}) else $error("stack reload wrong");
  call_push_a: assert property (disable iff (!rst_n) tk && cmd.op == OP_CALL
    |=> ea == $past(regs.sp) && regs.sp == $past(regs.sp) - RET_BYTES) else $error("call bad");
  int_push_a: assert property (disable iff (!rst_n) tk && cmd.op == OP_INT
    |=> regs.sp == $past(regs.sp) - INT_BYTES && regs.ccr[CCR_I]) else $error("int bad");
  bra_rel_a: assert property (disable iff (!rst_n) tk && cmd.op == OP_BRA
    |=> regs.pc == $past(regs.pc) + $past(rel) + $past(cmd.len)) else $error("branch bad");
  mov_post_a: assert property (disable iff (!rst_n) tk && cmd.op == OP_MOV && cmd.mov == MV_IXPD
    |=> regs.hx == $past(regs.hx) + 16'h0001 && ea == $past(regs.hx)) else $error("mov bad");
endmodule // cprf_core_asserts

// ### test/cprf_core_test.sv
`timescale 1ns/1ps
module cprf_core_test;
  import cprf_pkg::*;
  typedef struct packed {
    cprf_regs_t r;
    logic [15:0] ea;
    logic ck_ea;
    logic [15:0] ea2;
  } cprf_exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  cprf_cmd_t cmd = '0;
  logic [15:0] vec = 16'h0000;
  logic [7:0] vec_data;
  logic ready;
  logic [15:0] vec_addr;
  cprf_regs_t regs;
  logic [15:0] ea;
  logic [15:0] ea2;
  cprf_exp_t q[$];
  cprf_exp_t m;
  cprf_exp_t e;
  logic pend = 1'b0;
  logic rdy_q = 1'b0;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'hb440_be15;
  always #2.5 clk = ~clk;
  // Vector memory answers at once, since the core reads it in the same cycle
  assign vec_data = (vec_addr === VEC_HI) ? vec[15:8] : vec[7:0];
  cprf_core i_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .vec_data(vec_data), .ready(ready), .vec_addr(vec_addr), .regs(regs), .ea(ea), .ea2(ea2));
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic run(cprf_op_t op, cprf_mode_t md, logic [15:0] opr, logic [1:0] ln);
    logic [7:0] x;
    logic c;
    logic [15:0] rel;
    x = m.r.hx[7:0];
    c = m.r.ccr[CCR_C];
    rel = {{8{opr[7]}}, opr[7:0]};
    m.ck_ea = 1'b0;
    m.r.pc = m.r.pc + 16'(ln);
    case (op)
      OP_LDA: m.r.acc = opr[7:0];
      OP_ADD: {c, m.r.acc} = {1'b0, m.r.acc} + {1'b0, opr[7:0]};
      OP_SUB: {c, m.r.acc} = {1'b0, m.r.acc} - {1'b0, opr[7:0]};
      OP_LDX: x = opr[7:0];
      OP_LDHX: {m.r.hx[15:8], x} = opr;
      OP_CLRX: x = 8'h00;
      OP_INCX: x = x + 8'h01;
      OP_DECX: x = x - 8'h01;
      OP_COMX: {c, x} = {1'b1, ~x};
      OP_NEGX: {c, x} = {x != 8'h00, 8'h00 - x};
      OP_LSLX: {c, x} = {x, 1'b0};
      OP_LSRX: {x, c} = {1'b0, x};
      OP_ASRX: {x, c} = {x[7], x};
      OP_ROLX: {c, x} = {x, c};
      OP_RORX: {x, c} = {c, x};
      OP_MUL: {c, x, m.r.acc} = {1'b0, 16'(x) * 16'(m.r.acc)};
      OP_AIS: m.r.sp = m.r.sp + rel;
      OP_RSP: m.r.sp[7:0] = SP_LOW_RELOAD;
      OP_BRA: m.r.pc = m.r.pc + rel;
      OP_CALL, OP_INT: begin
        m.ea = m.r.sp;
        m.ck_ea = 1'b1;
        m.r.sp = m.r.sp - ((op == OP_CALL) ? RET_BYTES : INT_BYTES);
        m.r.ccr[CCR_I] = m.r.ccr[CCR_I] | (op == OP_INT);
        m.r.pc = opr;
      end
      OP_MOV: begin
        m.ea = m.r.hx;
        m.ea2 = {8'h00, opr[7:0]};
        m.ck_ea = 1'b1;
        {m.r.hx[15:8], x} = m.r.hx + 16'h0001;
      end
      default: ;
    endcase
    m.r.hx[7:0] = x;
    m.r.ccr[CCR_C] = c;
    q.push_back(m);
    cmd_valid <= 1'b1;
    cmd <= '{op: op, mode: md, mov: MV_IXPD, len: ln, opr: opr, aux: 8'h00};
    @(posedge clk);
  endtask
  // A stack adjust is held through reset and vector load; it must be ignored
  task automatic do_reset();
    vec = 16'($random(seed));
    m.r.hx[15:8] = H_RST;
    m.r.sp = SP_RST;
    m.r.ccr = CCR_RST;
    m.r.pc = vec;
    m.ea2 = 16'h0000;
    m.ck_ea = 1'b0;
    q.push_back(m);
    rst_n <= 1'b0;
    cmd_valid <= 1'b1;
    cmd <= '{op: OP_AIS, mode: AM_IMM, mov: MV_DD, len: 2'd2, opr: 16'h00f0, aux: 8'h00};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pend || (ready === 1'b1 && rdy_q === 1'b0)) begin
      if (q.size() == 0) begin
        chk("queue", 16'h0000, 16'hffff);
      end else begin
        e = q.pop_front();
        chk("acc", {8'h00, e.r.acc}, {8'h00, regs.acc});
        chk("hx", e.r.hx, regs.hx);
        chk("sp", e.r.sp, regs.sp);
        chk("pc", e.r.pc, regs.pc);
        chk("ccr", {8'h00, e.r.ccr & 8'h69}, {8'h00, regs.ccr & 8'h69});
        if (e.ck_ea) chk("ea", e.ea, ea);
        chk("ea2", e.ea2, ea2);
      end
    end
    pend <= cmd_valid && ready && rst_n;
    rdy_q <= ready;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    m = 'x;
    do_reset();
    run(OP_LDA, AM_IMM, 16'($random(seed)), 2'd2);
    run(OP_ADD, AM_IMM, 16'($random(seed)), 2'd2);
    run(OP_SUB, AM_IMM, 16'($random(seed)), 2'd2);
    run(OP_LDX, AM_IMM, 16'($random(seed)), 2'd2);
    do_reset();
    run(OP_LDHX, AM_IMM, 16'h12ff, 2'd3);
    for (int k = 0; k < 3; k++) begin
      for (int o = OP_CLRX; o <= OP_RORX; o++) begin
        run(cprf_op_t'(o), AM_INH, 16'h0000, 2'd1);
      end
      run(OP_MUL, AM_INH, 16'h0000, 2'd1);
      run(OP_LDX, AM_IMM, 16'($random(seed)), 2'd2);
    end
    for (int k = 0; k < 4; k++) begin
      run(OP_AIS, AM_IMM, 16'h0080, 2'd2);
    end
    run(OP_AIS, AM_IMM, 16'($random(seed)), 2'd2);
    run(OP_RSP, AM_INH, 16'h0000, 2'd1);
    run(OP_CALL, AM_EXT, 16'($random(seed)), 2'd3);
    run(OP_BRA, AM_REL, 16'h0080, 2'd2);
    run(OP_BRA, AM_REL, 16'h007f, 2'd2);
    run(OP_INT, AM_INH, 16'($random(seed)), 2'd1);
    run(OP_LDHX, AM_IMM, 16'hffff, 2'd3);
    run(OP_MOV, AM_IXP, 16'h0040, 2'd2);
    run(OP_MOV, AM_IXP, 16'h0040, 2'd2);
    cmd_valid <= 1'b0;
    repeat (3) @(posedge clk);
    do_reset();
    repeat (2) @(posedge clk);
    chk("left", 16'h0000, 16'(q.size()));
    complete_run();
  end
endmodule // cprf_core_test
bind cprf_core cprf_core_asserts i_chk (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd(cmd), .vec_data(vec_data), .ready(ready), .vec_addr(vec_addr), .regs(regs), .ea(ea),
  .ea2(ea2));
